// file: hw/unm_regs.svh
// Register offsets, field positions, reset values and codes of the network modem block
`ifndef UNM_REGS_SVH
`define UNM_REGS_SVH

// ==================================================
// Byte addresses
`define UNM_OFS_MODEM    32'hffff_0718
`define UNM_OFS_SCRATCH  32'hffff_071c
`define UNM_OFS_NETCTL   32'hffff_0720
`define UNM_OFS_NETID    32'hffff_0724
`define UNM_OFS_NODEADR  32'hffff_0728
`define UNM_OFS_FRAC     32'hffff_072c

// ==================================================
// Reset values
`define UNM_RST_SCRATCH  8'h00
`define UNM_RST_NETCTL   8'h04
`define UNM_RST_NETID    8'h01
`define UNM_RST_NODEADR  8'haa
`define UNM_RST_FRAC     16'h0000

// ==================================================
// Network enable control fields
`define UNM_NE_MODE      7
`define UNM_NE_TX9       6
`define UNM_NE_RX9       5
`define UNM_NE_IRQ       4
`define UNM_NE_WORD9     3
`define UNM_NE_DRV       2
`define UNM_NE_POL       1
`define UNM_NE_ABIT      0

// ==================================================
// Fractional divide fields
`define UNM_FR_EN        15
`define UNM_FR_M_HI      12
`define UNM_FR_M_LO      11
`define UNM_FR_N_HI      10
`define UNM_FR_M_ZERO_AS 3'h4

// ==================================================
// Network interrupt codes (bits 3:1)
`define UNM_ID_NONE      3'h0
`define UNM_ID_MATCH     3'h6
`define UNM_ID_ADDR_TX   3'h5

`endif

// file: hw/unm_pkg.sv
// Types shared by the network modem block
package unm_pkg;

  // Modem input levels, in status register order
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } unm_modem_s;

  // A received frame from the core receiver
  typedef struct packed {
    logic       valid;
    logic       ninth;
    logic [7:0] data;
  } unm_rx_frame_s;

  // Format controls handed to the core
  typedef struct packed {
    logic parity_allow;
    logic tx_nine;
    logic rx_nine;
    logic word_nine;
    logic tx_ninth_bit;
  } unm_mode_s;

endpackage

// file: hw/unm_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none

module unm_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

`default_nettype wire

// file: hw/unm_net_id.sv
// Priority encoder for the network interrupt identification value
`timescale 1ns/10ps
`default_nettype none

`include "unm_regs.svh"

module unm_net_id (
  // Pending sources
  input  wire logic       match_in,
  input  wire logic       addr_tx_in,
  // Identification byte
  output logic      [7:0] id_out
);

  // Address match outranks the transmitted address event
  logic [2:0] code;
  logic       none_pending;

  assign code = match_in   ? `UNM_ID_MATCH :
                addr_tx_in ? `UNM_ID_ADDR_TX : `UNM_ID_NONE;
  assign none_pending = ~(match_in | addr_tx_in);
  assign id_out = {4'h0, code, none_pending};

endmodule

`default_nettype wire

// file: hw/unm_top.sv
// Modem status, scratch, fractional divide control and network address mode
`timescale 1ns/10ps
`default_nettype none

`include "unm_regs.svh"

// Functional notes
// [R1] Carrier-detect change since last status read sets a flag; status read clears it.
// [R2] Ring input rising since last status read sets a flag; status read clears it.
// [R3] Data-set-ready change since last status read sets a flag; read clears it.
// [R4] Clear-to-send change sets bit 0 flag; status read clears it.
// [R5] Bits 7:4 show synchronised modem input levels; edges seen after synchronising.
// [R6] Eight-bit scratch register, resets to zero, no side effects.
// [R7] Divide bit 15 selects fractional generator, else integer generator.
// [R8] M field bits 12:11, N field bits 10:0; M of zero means four.
// [R9] Network mode only while control bit 7 set; no parity then.
// [R10] Supports 256 nodes with 8-bit addresses, single master or multimaster.
// [R11] In network mode the ninth transmitted bit comes from control bit 0.
// [R12] Control bit 6 enables 9-bit transmit, only with network mode.
// [R13] Control bit 5 enables 9-bit receive, only with network mode.
// [R14] Control bit 3 selects 9-bit data word when 9-bit transmit off.
// [R15] Control bit 2 enables output driver; resets to 0x04, driver on.
// [R16] Bit 4 gates network interrupt; bit 1 sets polarity and qualifies bit 0.
// [R17] Id register: code in 3:1, active-low pending in 0; 110 and 101.
// [R18] Match cleared by receive read; address-sent by transmit write or primary id read.
// [R19] Address frames compared with node address register, reset 0xAA; match flags.
// [R20] Software must enable receive-full interrupt for match interrupts to reach the processor.
// [R21] Master sets address bit, writes address, waits empty, clears bit, writes data.
module unm_top
  import unm_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk_in,
  input  wire logic          rst_b_in,
  // Register port
  input  wire logic [31:0]   addr_in,
  input  wire logic [15:0]   wdata_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  output logic      [15:0]   rdata_out,
  // Modem pins
  input  wire unm_modem_s    modem_in,
  // Core receiver and transmitter events
  input  wire unm_rx_frame_s rx_frame_in,
  input  wire logic          rx_buf_read_in,
  input  wire logic          tx_buf_write_in,
  input  wire logic          primary_id_read_in,
  input  wire logic          tx_empty_in,
  input  wire logic          rx_full_irq_en_in,
  // Core controls
  output unm_mode_s          mode_out,
  output logic               frac_gen_enable_out,
  output logic      [2:0]    frac_m_field_out,
  output logic      [10:0]   frac_n_field_out,
  output logic               serial_out_oe_b_out,
  output logic               net_irq_out
);

  // ==================================================
  // Helpers
  // Full 32-bit compare: aliases elsewhere in the map must not hit these registers
  function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] ofs);
    return (addr == ofs);
  endfunction

  // Either direction counts as a change of a synchronised level
  function automatic logic level_moved(input logic now_lvl, input logic prev_lvl);
    return now_lvl ^ prev_lvl;
  endfunction

  // ==================================================
  // Register decode
  logic sel_modem;
  logic sel_scratch;
  logic sel_netctl;
  logic sel_netid;
  logic sel_nodeadr;
  logic sel_frac;

  assign sel_modem   = addr_hit(addr_in, `UNM_OFS_MODEM);
  assign sel_scratch = addr_hit(addr_in, `UNM_OFS_SCRATCH);
  assign sel_netctl  = addr_hit(addr_in, `UNM_OFS_NETCTL);
  assign sel_netid   = addr_hit(addr_in, `UNM_OFS_NETID);
  assign sel_nodeadr = addr_hit(addr_in, `UNM_OFS_NODEADR);
  assign sel_frac    = addr_hit(addr_in, `UNM_OFS_FRAC);

  logic wr_scratch;
  logic wr_netctl;
  logic wr_nodeadr;
  logic wr_frac;
  logic rd_modem;

  assign wr_scratch = wr_in & sel_scratch;
  assign wr_netctl  = wr_in & sel_netctl;
  assign wr_nodeadr = wr_in & sel_nodeadr;
  assign wr_frac    = wr_in & sel_frac;
  assign rd_modem   = rd_in & sel_modem;

  // ==================================================
  // Modem status
  unm_modem_s modem_now;
  unm_modem_s modem_prev_reg;
  logic [3:0] delta_reg;
  logic [3:0] delta_set;
  logic [3:0] delta_next;
  logic [3:0] delta_raw;
  logic [1:0] prime_reg;
  logic       armed;

  // Pins cross two flops before edge detection
  unm_sync #(
    .WIDTH (4)
  ) u_sync (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .async_in (modem_in),
    .sync_out (modem_now)  // see [R5]
  );

  assign delta_raw[3] = level_moved(modem_now.dcd, modem_prev_reg.dcd);  // see [R1]
  assign delta_raw[2] = modem_now.ri & ~modem_prev_reg.ri;               // see [R2]
  assign delta_raw[1] = level_moved(modem_now.dsr, modem_prev_reg.dsr);  // see [R3]
  assign delta_raw[0] = level_moved(modem_now.cts, modem_prev_reg.cts);  // see [R4]

  // The synchroniser leaves reset at zero, so the first real pin level would look like
  // a change; edges count from the fourth edge after reset, earlier changes raise no flag
  assign armed     = (prime_reg == 2'h3);
  assign delta_set = delta_raw & {4{armed}};

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prime_reg <= 2'h0;
    end else if (!armed) begin
      prime_reg <= prime_reg + 2'h1;
    end
  end

  // A change in the read cycle survives the clear
  assign delta_next = (delta_reg & ~{4{rd_modem}}) | delta_set;  // see [R1] see [R2] see [R3] see [R4]

  logic [7:0] modem_status;

  assign modem_status = {modem_now, delta_reg};  // see [R5]

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      modem_prev_reg <= '0;
      delta_reg      <= 4'h0;
    end else begin
      modem_prev_reg <= modem_now;
      delta_reg      <= delta_next;
    end
  end

  // ==================================================
  // Scratch, control, node address and divide registers
  logic [7:0]  scratch_reg;
  logic [7:0]  netctl_reg;
  logic [7:0]  nodeadr_reg;
  logic [15:0] frac_reg;
  logic [15:0] frac_wmask;

  // Reserved divide bits 14:13 stay zero
  assign frac_wmask = 16'h9fff;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scratch_reg <= `UNM_RST_SCRATCH;  // see [R6]
      nodeadr_reg <= `UNM_RST_NODEADR;  // see [R19]
    end else begin
      if (wr_scratch) begin
        scratch_reg <= wdata_in[7:0];  // see [R6]
      end
      if (wr_nodeadr) begin
        nodeadr_reg <= wdata_in[7:0];  // see [R10]
      end
    end
  end

  // Control and divide writes land at the strobe edge; decoded copies follow one edge later
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      netctl_reg <= `UNM_RST_NETCTL;  // see [R15]
      frac_reg   <= `UNM_RST_FRAC;
    end else begin
      if (wr_netctl) begin
        netctl_reg <= wdata_in[7:0];
      end
      if (wr_frac) begin
        frac_reg <= wdata_in & frac_wmask;
      end
    end
  end

  // ==================================================
  // Network mode controls
  logic net_mode;
  logic tx_nine;
  logic rx_nine;
  logic word_nine;
  logic addr_pol;
  logic tx_ninth;

  assign net_mode  = netctl_reg[`UNM_NE_MODE];                    // see [R9]
  assign tx_nine   = net_mode & netctl_reg[`UNM_NE_TX9];          // see [R12]
  assign rx_nine   = net_mode & netctl_reg[`UNM_NE_RX9];          // see [R13]
  assign word_nine = netctl_reg[`UNM_NE_WORD9] & ~tx_nine;        // see [R14]
  assign addr_pol  = netctl_reg[`UNM_NE_POL];
  // Address bit counts only when the polarity bit qualifies it
  assign tx_ninth  = tx_nine & addr_pol & netctl_reg[`UNM_NE_ABIT];  // see [R11] see [R16]

  unm_mode_s mode_next;

  assign mode_next.parity_allow = ~net_mode;  // see [R9]
  assign mode_next.tx_nine      = tx_nine;
  assign mode_next.rx_nine      = rx_nine;
  assign mode_next.word_nine    = word_nine;
  assign mode_next.tx_ninth_bit = tx_ninth;

  // ==================================================
  // Fractional divide decode
  logic [2:0] m_next;

  assign m_next = (frac_reg[`UNM_FR_M_HI:`UNM_FR_M_LO] == 2'h0) ?
                  `UNM_FR_M_ZERO_AS :
                  {1'b0, frac_reg[`UNM_FR_M_HI:`UNM_FR_M_LO]};  // see [R8]

  // ==================================================
  // Network events
  logic match_reg;
  logic addr_tx_reg;
  logic addr_pend_reg;
  logic match_set;
  logic addr_sent;

  // An address frame carries the ninth bit at the selected polarity
  assign match_set = rx_nine & rx_frame_in.valid &
                     (rx_frame_in.ninth == addr_pol) &
                     (rx_frame_in.data == nodeadr_reg);  // see [R19] see [R16]

  // Address left the holding buffer once the core reports empty
  assign addr_sent = addr_pend_reg & tx_empty_in & ~tx_buf_write_in;

  // Set beats clear in one cycle, so an event that meets its clear is kept, except address-sent, which a transmit write suppresses
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      match_reg     <= 1'b0;
      addr_tx_reg   <= 1'b0;
      addr_pend_reg <= 1'b0;
    end else begin
      match_reg <= match_set | (match_reg & ~rx_buf_read_in);  // see [R18]
      addr_tx_reg <= addr_sent |
                     (addr_tx_reg & ~tx_buf_write_in & ~primary_id_read_in);  // see [R18]
      if (tx_buf_write_in) begin
        addr_pend_reg <= tx_ninth;  // see [R21]
      end else if (addr_sent) begin
        addr_pend_reg <= 1'b0;
      end
    end
  end

  logic [7:0] net_id;

  unm_net_id u_net_id (
    .match_in   (match_reg),
    .addr_tx_in (addr_tx_reg),
    .id_out     (net_id)  // see [R17]
  );

  // Match reaches the processor only with receive-full enabled;
  // the address-sent event raises it on its own
  logic irq_next;

  assign irq_next = netctl_reg[`UNM_NE_IRQ] &
                    ((match_reg & rx_full_irq_en_in) | addr_tx_reg);  // see [R16] see [R20]

  // ==================================================
  // Read data, one cycle after the strobe
  // Unmapped addresses and the reserved divide bits read as zero
  logic [15:0] rd_mux;

  assign rd_mux = sel_modem   ? {8'h00, modem_status} :
                  sel_scratch ? {8'h00, scratch_reg}  :
                  sel_netctl  ? {8'h00, netctl_reg}   :
                  sel_netid   ? {8'h00, net_id}       :
                  sel_nodeadr ? {8'h00, nodeadr_reg}  :
                  sel_frac    ? frac_reg : 16'h0000;

  // ==================================================
  // Output flops
  logic [15:0] rdata_reg;
  unm_mode_s   mode_reg;
  logic        frac_en_reg;
  logic [2:0]  frac_m_reg;
  logic [10:0] frac_n_reg;
  logic        oe_b_reg;
  logic        irq_reg;

  // Read data is zero outside its one valid cycle, so a late sample cannot pass
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rd_in ? rd_mux : 16'h0000;
    end
  end

  // Format controls, driver enable and interrupt lag the control register by one edge
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_reg <= '0;
      oe_b_reg <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      oe_b_reg <= ~netctl_reg[`UNM_NE_DRV];  // see [R15]
      irq_reg  <= irq_next;
    end
  end

  // Divide fields reach the generator together
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      frac_en_reg <= 1'b0;
      frac_m_reg  <= `UNM_FR_M_ZERO_AS;
      frac_n_reg  <= 11'h000;
    end else begin
      frac_en_reg <= frac_reg[`UNM_FR_EN];  // see [R7]
      frac_m_reg  <= m_next;                // see [R8]
      frac_n_reg  <= frac_reg[`UNM_FR_N_HI:0];
    end
  end

  assign rdata_out           = rdata_reg;
  assign mode_out            = mode_reg;
  assign frac_gen_enable_out = frac_en_reg;
  assign frac_m_field_out    = frac_m_reg;
  assign frac_n_field_out    = frac_n_reg;
  assign serial_out_oe_b_out = oe_b_reg;
  assign net_irq_out         = irq_reg;

endmodule

`default_nettype wire

// file: verif/unm_top_checker.sv
// Port-level assertions of the network modem block
`timescale 1ns/10ps
`default_nettype none
`include "unm_regs.svh"
module unm_top_checker
  import unm_pkg::*;
(
  // Clock and reset
  input wire logic        mclk_in,
  input wire logic        rst_b_in,
  // Register port
  input wire logic [31:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  // Pins and core controls
  input wire unm_modem_s  modem_in,
  input wire unm_mode_s   mode_out,
  input wire logic        frac_gen_enable_out,
  input wire logic [2:0]  frac_m_field_out,
  input wire logic [10:0] frac_n_field_out,
  input wire logic        serial_out_oe_b_out
);
  default clocking dc @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  // ==========================================
  // Helpers
  // Controls follow a write two edges later, so keep the data that far back
  logic [15:0] w1_reg;
  logic [15:0] w2_reg;
  logic [2:0]  calm_reg;
  unm_modem_s  seen_reg;
  logic        clean_reg;
  wire         ctl_wr = wr_in && addr_in == `UNM_OFS_NETCTL;
  wire         frac_wr = wr_in && addr_in == `UNM_OFS_FRAC;
  wire         mod_rd = rd_in && addr_in == `UNM_OFS_MODEM;
  wire         moved = modem_in != seen_reg;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      w1_reg    <= 16'h0000;
      w2_reg    <= 16'h0000;
      calm_reg  <= 3'h0;
      seen_reg  <= '0;
      clean_reg <= 1'b0;
    end else begin
      w1_reg    <= wdata_in;
      w2_reg    <= w1_reg;
      seen_reg  <= modem_in;
      calm_reg  <= moved ? 3'h0 : (calm_reg == 3'h7 ? 3'h7 : calm_reg + 3'h1);
      clean_reg <= moved ? 1'b0 : ((mod_rd && calm_reg >= 3'h5) | clean_reg);
    end
  end
  // ==========================================
  // Assertions
  a_ctl_parity: assert property (ctl_wr |=> ##1 mode_out.parity_allow == !w2_reg[7])
    else $error("parity permission wrong");
  a_ctl_tx_nine: assert property (ctl_wr |=> ##1 mode_out.tx_nine == (w2_reg[7] & w2_reg[6]))
    else $error("nine bit transmit wrong");
  a_ctl_word_nine: assert property (ctl_wr |=> ##1 mode_out.word_nine == (w2_reg[3] & !(w2_reg[7] & w2_reg[6])))
    else $error("word length wrong");
  a_drv_enable: assert property (ctl_wr |=> ##1 serial_out_oe_b_out == !w2_reg[2])
    else $error("driver enable wrong");
  a_frac_m_map: assert property (frac_wr |=> ##1 frac_m_field_out == (w2_reg[12:11] == 2'b00 ? 3'h4 : {1'b0, w2_reg[12:11]}))
    else $error("fractional M wrong");
  a_frac_select: assert property (frac_wr |=> ##1 {frac_gen_enable_out, frac_n_field_out} == {w2_reg[15], w2_reg[10:0]})
    else $error("fractional select or N wrong");
  a_id_format: assert property (rd_in && addr_in == `UNM_OFS_NETID |=> rdata_out[0] == (rdata_out[3:1] == 3'h0) && rdata_out[15:4] == 12'h000)
    else $error("id pending flag wrong");
  a_modem_levels: assert property (mod_rd && calm_reg >= 3'h5 |=> rdata_out[7:4] == seen_reg)
    else $error("modem levels wrong");
  a_delta_clear: assert property (mod_rd && clean_reg |=> rdata_out[3:0] == 4'h0)
    else $error("modem change flags not cleared");
endmodule
bind unm_top unm_top_checker chk (.mclk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .modem_in,
  .mode_out, .frac_gen_enable_out, .frac_m_field_out, .frac_n_field_out, .serial_out_oe_b_out);
`default_nettype wire

// file: verif/unm_far_node.sv
// Far side: a remote node whose frames reach the receiver, and the transmit drain
`timescale 1ns/10ps
`default_nettype none
module unm_far_node
  import unm_pkg::*;
#(
  parameter int DRAIN = 6
) (
  // Clock
  input  wire logic     mclk_in,
  // Transmit side
  input  wire logic     tx_buf_write_in,
  output logic          tx_empty_out,
  // Receive side
  output unm_rx_frame_s rx_frame_out
);
  int cnt = 0;
  // Holding buffer stays busy while the remote line shifts the word out
  assign tx_empty_out = (cnt == 0);
  always @(posedge mclk_in) begin
    if (tx_buf_write_in) begin
      cnt <= DRAIN;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  initial begin
    rx_frame_out = '0;
  end
  // Data is inverted once the frame is gone so nothing stale looks valid
  task automatic send(input logic ninth, input logic [7:0] data);
    @(posedge mclk_in);
    rx_frame_out <= '{1'b1, ninth, data};
    @(posedge mclk_in);
    rx_frame_out <= '{1'b0, !ninth, ~data};
  endtask
endmodule
`default_nettype wire

// file: verif/unm_top_bench.sv
// Self-checking bench of the network modem block
`timescale 1ns/10ps
`default_nettype none
`include "unm_regs.svh"
module unm_top_bench
  import unm_pkg::*;
;
  localparam int DRAIN = 6;
  logic          mclk_in = 1'b0;
  logic          rst_b_in = 1'b0;
  logic [31:0]   addr_in = 32'h0000_0000;
  logic [15:0]   wdata_in = 16'h0000;
  logic          wr_in = 1'b0;
  logic          rd_in = 1'b0;
  logic [3:0]    ev = 4'h0;
  unm_modem_s    modem_in = '0;
  unm_rx_frame_s frame;
  unm_mode_s     mode;
  logic          empty, fen, oe_b, irq;
  logic [2:0]    fm;
  logic [10:0]   fn;
  logic [15:0]   rdata;
  int            fail_count = 0;
  int            samples_checked = 0;
  int            cyc = 0;
  logic [31:0]   ra [7] = '{`UNM_OFS_MODEM, `UNM_OFS_SCRATCH, `UNM_OFS_NETCTL, `UNM_OFS_NETID, `UNM_OFS_NODEADR,
                            `UNM_OFS_FRAC, 32'hffff_0730};
  logic [15:0]   rv [7] = '{16'h0000, 16'h0000, 16'h0004, 16'h0001, 16'h00aa, 16'h0000, 16'h0000};
  logic [7:0]    cw [4] = '{8'hf3, 8'ha8, 8'hc8, 8'h6c};
  logic [5:0]    cx [4] = '{6'h2d, 6'h26, 6'h28, 6'h12};
  logic [3:0]    mi [3] = '{4'hf, 4'h4, 4'h2};
  logic [15:0]   mo [3] = '{16'h00ff, 16'h004b, 16'h0022};
  always #12.5 mclk_in = ~mclk_in;
  // ev: 0 receive read, 1 transmit write, 2 primary id read, 3 receive-full enable
  unm_top dut (.mclk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out(rdata), .modem_in,
    .rx_frame_in(frame), .rx_buf_read_in(ev[0]), .tx_buf_write_in(ev[1]), .primary_id_read_in(ev[2]),
    .tx_empty_in(empty), .rx_full_irq_en_in(ev[3]), .mode_out(mode), .frac_gen_enable_out(fen),
    .frac_m_field_out(fm), .frac_n_field_out(fn), .serial_out_oe_b_out(oe_b), .net_irq_out(irq));
  unm_far_node #(.DRAIN(DRAIN)) far (.mclk_in, .tx_buf_write_in(ev[1]), .tx_empty_out(empty), .rx_frame_out(frame));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    wdata_in <= ~d;
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic pulse(input int k);
    @(posedge mclk_in);
    ev[k] <= 1'b1;
    @(posedge mclk_in);
    ev[k] <= 1'b0;
  endtask
  task automatic results();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
    check({10'h000, oe_b, mode}, 16'h0010);
    wr(`UNM_OFS_SCRATCH, 16'h005a);
    rd(`UNM_OFS_SCRATCH, 16'h005a);
    wr(`UNM_OFS_FRAC, 16'hffff);
    rd(`UNM_OFS_FRAC, 16'h9fff);
    check({1'b0, fen, fm, fn}, 16'h5fff);
    wr(`UNM_OFS_FRAC, 16'h0123);
    idle(3);
    check({1'b0, fen, fm, fn}, 16'h2123);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_in);
      modem_in <= mi[i];
      idle(6);
      rd(`UNM_OFS_MODEM, mo[i]);
    end
    rd(`UNM_OFS_MODEM, 16'h0020);
    for (int i = 0; i < 4; i++) begin
      wr(`UNM_OFS_NETCTL, {8'h00, cw[i]});
      idle(3);
      check({10'h000, oe_b, mode}, {10'h000, cx[i]});
    end
    wr(`UNM_OFS_NETCTL, 16'h00f3);
    wr(`UNM_OFS_NODEADR, 16'h003c);
    rd(`UNM_OFS_NODEADR, 16'h003c);
    far.send(1'b1, 8'h55);
    far.send(1'b0, 8'h3c);
    idle(3);
    rd(`UNM_OFS_NETID, 16'h0001);
    far.send(1'b1, 8'h3c);
    idle(3);
    rd(`UNM_OFS_NETID, 16'h000c);
    check({15'h0000, irq}, 16'h0000);
    @(posedge mclk_in);
    ev[3] <= 1'b1;
    idle(3);
    check({15'h0000, irq}, 16'h0001);
    pulse(0);
    idle(3);
    rd(`UNM_OFS_NETID, 16'h0001);
    pulse(1);
    idle(DRAIN + 4);
    rd(`UNM_OFS_NETID, 16'h000a);
    check({15'h0000, irq}, 16'h0001);
    far.send(1'b1, 8'h3c);
    idle(3);
    rd(`UNM_OFS_NETID, 16'h000c);
    pulse(0);
    idle(3);
    rd(`UNM_OFS_NETID, 16'h000a);
    wr(`UNM_OFS_NETCTL, 16'h00e3);
    idle(3);
    check({15'h0000, irq}, 16'h0000);
    pulse(2);
    idle(3);
    rd(`UNM_OFS_NETID, 16'h0001);
    // A level held high across a reset must not come back as a change
    @(posedge mclk_in);
    rst_b_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    idle(6);
    rd(`UNM_OFS_MODEM, 16'h0020);
    rd(`UNM_OFS_NETCTL, 16'h0004);
    results();
  end
endmodule
`default_nettype wire
